// *** cost_if.sv ***
// carrier between the core and its cost calculator
`timescale 1ns/1ps
`default_nettype none

interface cost_if;
  import prefetch_timing_pkg::*;
  ea_mode_t src_mode;
  ea_mode_t dst_mode;
  logic op_long;
  logic index_long;
  logic [7:0] ea_periods;
  logic [3:0] ea_reads;
  logic [3:0] ea_writes;
  logic [7:0] move_periods;
  logic [3:0] move_reads;
  logic [3:0] move_writes;

  modport calc(
    input src_mode, dst_mode, op_long, index_long,
    output ea_periods, ea_reads, ea_writes,
    output move_periods, move_reads, move_writes
  );
  modport user(
    output src_mode, dst_mode, op_long, index_long,
    input ea_periods, ea_reads, ea_writes,
    input move_periods, move_reads, move_writes
  );
endinterface : cost_if

`default_nettype wire

// *** ea_cost_calc.sv ***
// address evaluation and move cost lookup, registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "prefetch_timing_defs.svh"

module ea_cost_calc import prefetch_timing_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  cost_if.calc cost
);

  ////////////////////////////////////////////////////////////////////////
  // lookups

  // word cost of a source operand as {periods, reads}
  function automatic logic [11:0] src_word_cost(input ea_mode_t m);
    case (m)
      MODE_IND, MODE_POSTINC: src_word_cost = {`EA_IND_P, `EA_IND_R};
      MODE_PREDEC: src_word_cost = {`EA_PREDEC_P, `EA_PREDEC_R};
      MODE_DISP, MODE_ABSW, MODE_PCDISP: src_word_cost = {`EA_DISP_P, `EA_DISP_R};
      MODE_INDEX, MODE_PCINDEX: src_word_cost = {`EA_INDEX_P, `EA_INDEX_R};
      MODE_ABSL: src_word_cost = {`EA_ABSL_P, `EA_ABSL_R};
      MODE_IMM: src_word_cost = {`EA_IMM_P, `EA_IMM_R};
      default: src_word_cost = {`EA_NONE_P, `EA_NONE_R};
    endcase
  endfunction : src_word_cost

  // destination address part, extension fetches only
  function automatic logic [11:0] dst_addr_cost(input ea_mode_t m);
    case (m)
      MODE_DISP, MODE_ABSW: dst_addr_cost = {`DST_DISP_P, `DST_DISP_R};
      MODE_INDEX: dst_addr_cost = {`DST_INDEX_P, `DST_INDEX_R};
      MODE_ABSL: dst_addr_cost = {`DST_ABSL_P, `DST_ABSL_R};
      default: dst_addr_cost = {`EA_NONE_P, `EA_NONE_R};
    endcase
  endfunction : dst_addr_cost

  ////////////////////////////////////////////////////////////////////////
  // cost sums

  // index size input is not looked at: same time either way
  wire [11:0] src_word = src_word_cost(cost.src_mode); // RULE_13
  wire [11:0] dst_addr = dst_addr_cost(cost.dst_mode);
  wire src_in_mem = (cost.src_mode != MODE_DREG) && (cost.src_mode != MODE_AREG);
  wire dst_in_mem = (cost.dst_mode != MODE_DREG) && (cost.dst_mode != MODE_AREG);
  wire long_extra = cost.op_long && src_in_mem;
  // long memory operands add one read and four periods
  wire [7:0] src_p = src_word[11:4] + (long_extra ? `LONG_EXTRA_P : 8'h00); // RULE_12
  wire [3:0] src_r = src_word[3:0] + (long_extra ? `LONG_EXTRA_R : 4'h0); // RULE_12
  // a long store takes two write cycles
  wire [3:0] dst_w = !dst_in_mem ? 4'h0 : (cost.op_long ? `WRITE_TWO : `WRITE_ONE);
  wire [7:0] dst_wp = cost.op_long ? (`WRITE_P + `WRITE_P) : `WRITE_P;
  wire [7:0] dst_p = dst_addr[11:4] + (dst_in_mem ? dst_wp : 8'h00);
  // move = opcode fetch + source + destination
  wire [7:0] mv_p = `MOVE_BASE_P + src_p + dst_p; // RULE_14
  wire [3:0] mv_r = `MOVE_BASE_R + src_r + dst_addr[3:0]; // RULE_15

  // output registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cost.ea_periods <= `COUNT8_RESET;
      cost.ea_reads <= `COUNT4_RESET;
      cost.ea_writes <= `COUNT4_RESET;
      cost.move_periods <= `COUNT8_RESET;
      cost.move_reads <= `COUNT4_RESET;
      cost.move_writes <= `COUNT4_RESET;
    end else begin
      cost.ea_periods <= src_p; // RULE_11
      cost.ea_reads <= src_r; // RULE_11
      cost.ea_writes <= `COUNT4_RESET; // RULE_10
      cost.move_periods <= mv_p;
      cost.move_reads <= mv_r;
      cost.move_writes <= dst_w; // RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_EA_NO_WRITE: assert property ( // RULE_10
    ##1 cost.ea_writes == 4'h0)
    else $error("address evaluation shows a write cycle");
  AST_EA_WORD_PREDEC: assert property ( // RULE_11
    (cost.src_mode == MODE_PREDEC && !cost.op_long) |=>
      (cost.ea_periods == 8'h06 && cost.ea_reads == 4'h1))
    else $error("word predecrement cost wrong");
  AST_EA_LONG_ABS: assert property ( // RULE_12
    (cost.src_mode == MODE_ABSL && cost.op_long) |=>
      (cost.ea_periods == 8'h10 && cost.ea_reads == 4'h4))
    else $error("long absolute cost wrong");
  AST_MOVE_REG: assert property ( // RULE_14
    (cost.src_mode == MODE_DREG && cost.dst_mode == MODE_DREG &&
     !cost.op_long) |=> (cost.move_periods == 8'h04 &&
     cost.move_reads == 4'h1 && cost.move_writes == 4'h0))
    else $error("register move cost wrong");
  AST_MOVE_LONG_ABS: assert property ( // RULE_15
    (cost.src_mode == MODE_ABSL && cost.dst_mode == MODE_ABSL &&
     cost.op_long) |=> (cost.move_periods == 8'h24 &&
     cost.move_reads == 4'h7 && cost.move_writes == 4'h2))
    else $error("long absolute move cost wrong");

endmodule : ea_cost_calc

`default_nettype wire

// *** mem_model.sv ***
// memory partner answering fetch and operand bus cycles
`timescale 1ns/1ps
`default_nettype none

module mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] waits,
  output logic [15:0] mem_rdata,
  output logic mem_ready,
  output logic [7:0] bus_len,
  output logic [15:0] wr_data
);
  logic [7:0] cnt_reg;
  logic [15:0] junk_reg;
  logic done;
  // ready on the fourth period, later by the wait count asked
  assign done = mem_req && (cnt_reg >= (8'h03 + {4'h0, waits}));
  assign mem_ready = done;
  // stored word is an address pattern; otherwise a changing junk value
  assign mem_rdata = (done && !mem_we) ? (mem_addr[15:0] ^ 16'hC3A5)
                                       : junk_reg;
  // period counter, last cycle length and last written word
  always_ff @(posedge clk) begin
    junk_reg <= junk_reg + 16'h1357;
    if (!nrst) begin
      cnt_reg <= 8'h00;
      bus_len <= 8'h00;
      wr_data <= 16'h0000;
      junk_reg <= 16'h5A5A;
    end else if (done) begin
      cnt_reg <= 8'h00;
      bus_len <= cnt_reg + 8'h01;
      if (mem_we) begin
        wr_data <= mem_wdata;
      end
    end else begin
      cnt_reg <= mem_req ? cnt_reg + 8'h01 : 8'h00;
    end
  end
endmodule : mem_model

`default_nettype wire

// *** prefetch_timing_defs.svh ***
// constants for the prefetch queue and the execution-time sequencer
`ifndef PREFETCH_TIMING_DEFS_SVH
`define PREFETCH_TIMING_DEFS_SVH

// bus cycle: four clock periods when memory answers at once
`define BUS_CYCLE_PERIODS 8'h04
`define BUS_LAST_PERIOD 3'h3
`define BUS_PERIOD_STEP 3'h1

// program counter
`define PC_RESET_VALUE 24'hFFFFFE
`define FETCH_STEP 24'h000002

// reset values
`define WORD_RESET 16'h0000
`define ADDR_RESET 24'h000000
`define COUNT16_RESET 16'h0000
`define COUNT4_RESET 4'h0
`define COUNT8_RESET 8'h00

// move base: opcode fetch
`define MOVE_BASE_P 8'h04
`define MOVE_BASE_R 4'h1
// one write bus cycle
`define WRITE_P 8'h04
`define WRITE_ONE 4'h1
`define WRITE_TWO 4'h2

// long operand: one more read, four more periods
`define LONG_EXTRA_P 8'h04
`define LONG_EXTRA_R 4'h1

// address evaluation cost, byte or word operand
`define EA_NONE_P 8'h00
`define EA_NONE_R 4'h0
`define EA_IND_P 8'h04
`define EA_IND_R 4'h1
`define EA_PREDEC_P 8'h06
`define EA_PREDEC_R 4'h1
`define EA_DISP_P 8'h08
`define EA_DISP_R 4'h2
`define EA_INDEX_P 8'h0A
`define EA_INDEX_R 4'h2
`define EA_ABSL_P 8'h0C
`define EA_ABSL_R 4'h3
`define EA_IMM_P 8'h04
`define EA_IMM_R 4'h1

// destination address part of a move, before the write itself
`define DST_DISP_P 8'h04
`define DST_DISP_R 4'h1
`define DST_INDEX_P 8'h06
`define DST_INDEX_R 4'h1
`define DST_ABSL_P 8'h08
`define DST_ABSL_R 4'h2

`endif

// *** prefetch_timing_note_end.sv ***
// intentionally empty compile unit marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** prefetch_timing_pkg.sv ***
// types shared by the prefetch queue and the cost calculator
package prefetch_timing_pkg;

  // operand addressing modes
  typedef enum logic [3:0] {
    MODE_DREG = 4'h0,
    MODE_AREG = 4'h1,
    MODE_IND = 4'h2,
    MODE_POSTINC = 4'h3,
    MODE_PREDEC = 4'h4,
    MODE_DISP = 4'h5,
    MODE_INDEX = 4'h6,
    MODE_ABSW = 4'h7,
    MODE_ABSL = 4'h8,
    MODE_PCDISP = 4'h9,
    MODE_PCINDEX = 4'hA,
    MODE_IMM = 4'hB
  } ea_mode_t;

  // bus sequencer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RUN = 2'b10
  } bus_state_t;

endpackage : prefetch_timing_pkg

// *** testbench.sv ***
// self-checking bench for the prefetch queue and timing block
`timescale 1ns/1ps
`default_nettype none

module testbench import prefetch_timing_pkg::*;;
  logic clk = 1'h0, nrst = 1'h0;
  logic mem_req, mem_we, mem_ready, op_done, exec_start;
  logic opcode_valid, next_valid;
  logic [23:0] mem_addr, program_counter;
  logic [15:0] mem_wdata, mem_rdata, op_rdata, opcode_word, next_word;
  logic [15:0] last_periods, last_reads, last_writes, wr_data, p0, p2, p1;
  logic [7:0] ea_periods, move_periods, bus_len;
  logic [3:0] ea_reads, ea_writes, move_reads, move_writes;
  logic op_req = 1'h0, op_we = 1'h0, ext_take = 1'h0, instr_done = 1'h0;
  logic branch_take = 1'h0, exc_take = 1'h0, op_long = 1'h0;
  logic index_long = 1'h0;
  logic [23:0] op_addr = 24'h0, jump_target = 24'h0;
  logic [15:0] op_wdata = 16'h0;
  logic [3:0] waits = 4'h0;
  ea_mode_t src_mode = MODE_DREG, dst_mode = MODE_DREG;
  int errors = 0, cmp_count = 0;

  two_word_prefetch_timing two_word_prefetch_timing_inst (.clk, .nrst,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready,
    .op_req, .op_we, .op_addr, .op_wdata, .op_done, .op_rdata,
    .exec_start, .opcode_word, .opcode_valid, .next_word, .next_valid,
    .ext_take, .instr_done, .branch_take, .exc_take, .jump_target,
    .src_mode, .dst_mode, .op_long, .index_long, .ea_periods, .ea_reads,
    .ea_writes, .move_periods, .move_reads, .move_writes, .last_periods,
    .last_reads, .last_writes, .program_counter);
  mem_model mem_model_inst (.clk, .nrst, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .waits, .mem_rdata, .mem_ready, .bus_len, .wr_data);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] word_at(input logic [23:0] a);
    return a[15:0] ^ 16'hC3A5;
  endfunction : word_at

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // wait for the next instruction start, bounded
  task automatic wait_start;
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (exec_start !== 1'h1 && n < 300);
    chk(exec_start, 24'h1);
    chk({opcode_valid, next_valid}, 24'h3);
  endtask : wait_start

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    tick(2);
    chk(program_counter, 24'hFFFFFE);
    chk({mem_req, op_done, exec_start, opcode_valid}, 24'h0);
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    wait_start;
    chk(opcode_word, word_at(24'h0));
    chk(next_word, word_at(24'h2));
    chk(program_counter, 24'h2);
    $display("test reset end");
  endtask : t_reset

  task automatic t_queue;
    @(posedge clk);
    ext_take <= 1'h1;
    @(posedge clk);
    ext_take <= 1'h0;
    tick(8);
    chk(next_word, word_at(24'h4));
    chk(opcode_word, word_at(24'h0));
    chk(program_counter, 24'h4);
    @(posedge clk);
    instr_done <= 1'h1;
    @(posedge clk);
    instr_done <= 1'h0;
    tick(1);
    chk({mem_req, mem_we, mem_addr}, {2'h2, 24'h6});
    wait_start;
    chk(opcode_word, word_at(24'h4));
    chk(next_word, word_at(24'h6));
    chk(program_counter, 24'h6);
    $display("test queue end");
  endtask : t_queue

  // one operand cycle inside an instruction, then its end
  task automatic t_op(input logic we, input logic [3:0] w,
      output logic [15:0] p);
    int n;
    n = 0;
    @(posedge clk);
    waits <= w;
    op_req <= 1'h1;
    op_we <= we;
    op_addr <= 24'h001000;
    op_wdata <= 16'hBEEF;
    do begin
      tick(1);
      n++;
    end while (op_done !== 1'h1 && n < 100);
    chk(bus_len, 24'h4 + w);
    if (we) begin
      chk(wr_data, 24'hBEEF);
    end else begin
      chk(op_rdata, word_at(24'h001000));
    end
    @(posedge clk);
    op_req <= 1'h0;
    instr_done <= 1'h1;
    @(posedge clk);
    instr_done <= 1'h0;
    wait_start;
    chk(last_writes, {23'h0, we});
    chk(last_reads, {23'h0, !we});
    p = last_periods;
    $display("test operand end");
  endtask : t_op

  task automatic t_flush(input logic br, input logic [23:0] t);
    @(posedge clk);
    ext_take <= !br;
    @(posedge clk);
    ext_take <= 1'h0;
    branch_take <= br;
    exc_take <= !br;
    jump_target <= t;
    @(posedge clk);
    branch_take <= 1'h0;
    exc_take <= 1'h0;
    #1;
    chk({opcode_valid, next_valid}, 24'h0);
    chk(mem_req, !br);
    wait_start;
    chk(opcode_word, word_at(t));
    chk(next_word, word_at(t + 24'h2));
    chk(program_counter, t + 24'h2);
    $display("test flush end");
  endtask : t_flush

  task automatic cc(input ea_mode_t s, input ea_mode_t d,
      input logic l, input logic x, input logic [7:0] ep,
      input logic [3:0] er, input logic [7:0] mp, input logic [3:0] mr,
      input logic [3:0] mw);
    @(posedge clk);
    src_mode <= s;
    dst_mode <= d;
    op_long <= l;
    index_long <= x;
    tick(2);
    chk({ea_periods, ea_reads, ea_writes}, {ep, er, 4'h0});
    chk({move_periods, move_reads, move_writes}, {mp, mr, mw});
  endtask : cc

  ////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    t_reset;
    t_queue;
    t_op(1'h0, 4'h0, p0);
    t_op(1'h0, 4'h2, p2);
    chk(p2 - p0, 24'h2);
    t_op(1'h1, 4'h0, p1);
    chk(p1, p0);
    t_flush(1'h1, 24'h000100);
    t_flush(1'h0, 24'h000200);
    cc(MODE_DREG, MODE_DREG, 0, 0, 0, 0, 4, 1, 0);
    cc(MODE_IND, MODE_DREG, 0, 0, 4, 1, 8, 2, 0);
    cc(MODE_POSTINC, MODE_DREG, 0, 0, 4, 1, 8, 2, 0);
    cc(MODE_PREDEC, MODE_DREG, 0, 0, 6, 1, 10, 2, 0);
    cc(MODE_DISP, MODE_DREG, 0, 0, 8, 2, 12, 3, 0);
    cc(MODE_INDEX, MODE_DREG, 0, 0, 10, 2, 14, 3, 0);
    cc(MODE_INDEX, MODE_DREG, 0, 1, 10, 2, 14, 3, 0);
    cc(MODE_ABSL, MODE_DREG, 0, 0, 12, 3, 16, 4, 0);
    cc(MODE_IMM, MODE_DREG, 0, 0, 4, 1, 8, 2, 0);
    cc(MODE_ABSW, MODE_DREG, 0, 0, 8, 2, 12, 3, 0);
    cc(MODE_PCINDEX, MODE_AREG, 0, 0, 10, 2, 14, 3, 0);
    cc(MODE_PCDISP, MODE_ABSW, 0, 0, 8, 2, 20, 4, 1);
    cc(MODE_AREG, MODE_AREG, 1, 0, 0, 0, 4, 1, 0);
    cc(MODE_DREG, MODE_DISP, 0, 0, 0, 0, 12, 2, 1);
    cc(MODE_DREG, MODE_INDEX, 1, 1, 0, 0, 18, 2, 2);
    cc(MODE_IND, MODE_DREG, 1, 0, 8, 2, 12, 3, 0);
    cc(MODE_PREDEC, MODE_DREG, 1, 0, 10, 2, 14, 3, 0);
    cc(MODE_DISP, MODE_DREG, 1, 0, 12, 3, 16, 4, 0);
    cc(MODE_INDEX, MODE_DREG, 1, 1, 14, 3, 18, 4, 0);
    cc(MODE_ABSL, MODE_DREG, 1, 0, 16, 4, 20, 5, 0);
    cc(MODE_DREG, MODE_IND, 0, 0, 0, 0, 8, 1, 1);
    cc(MODE_DREG, MODE_ABSL, 0, 0, 0, 0, 16, 3, 1);
    cc(MODE_DREG, MODE_IND, 1, 0, 0, 0, 12, 1, 2);
    cc(MODE_ABSL, MODE_ABSL, 1, 0, 16, 4, 36, 7, 2);
    $display("test cost end");
    give_verdict;
  end

  // run needs a few hundred cycles; cut off well beyond that
  initial begin
    #1000000;
    errors++;
    give_verdict;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
endmodule : testbench

`default_nettype wire

// *** two_word_prefetch_timing.sv ***
// two-word prefetch queue, bus sequencer and instruction time counter
// Behaviour
// RULE_01: a new instruction starts only when its opcode and the next word are both held.
// RULE_02: each extension word taken from the queue starts one refill fetch.
// RULE_03: dropping the opcode at instruction end starts the last fetch at once.
// RULE_04: a taken branch drops the already fetched second word unused.
// RULE_05: an interrupt or trace exception drops both queue words unused.
// RULE_06: the program counter holds the address of the last fetched word.
// RULE_07: every bus read or write lasts four clock periods at zero wait.
// RULE_08: each wait period of slow memory adds one period to instruction time.
// RULE_09: instruction time counts every fetch, operand read and store cycle.
// RULE_10: address evaluation never costs a write cycle.
// RULE_11: byte and word address evaluation cost follows the fixed mode table.
// RULE_12: long memory operands cost one more read and four more periods.
// RULE_13: the size of the index register never changes the cost.
// RULE_14: byte or word moves cost 4(1/0), 8(1/1) and 16(3/1) for the listed cases.
// RULE_15: long moves cost 12(1/2) to indirect and 36(7/2) absolute to absolute.
// RULE_16: after a branch or exception both words refill from the new place first.
`timescale 1ns/1ps
`default_nettype none
`include "prefetch_timing_defs.svh"

module two_word_prefetch_timing import prefetch_timing_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic op_req,
  input wire logic op_we,
  input wire logic [23:0] op_addr,
  input wire logic [15:0] op_wdata,
  output logic op_done,
  output logic [15:0] op_rdata,
  output logic exec_start,
  output logic [15:0] opcode_word,
  output logic opcode_valid,
  output logic [15:0] next_word,
  output logic next_valid,
  input wire logic ext_take,
  input wire logic instr_done,
  input wire logic branch_take,
  input wire logic exc_take,
  input wire logic [23:0] jump_target,
  input wire ea_mode_t src_mode,
  input wire ea_mode_t dst_mode,
  input wire logic op_long,
  input wire logic index_long,
  output logic [7:0] ea_periods,
  output logic [3:0] ea_reads,
  output logic [3:0] ea_writes,
  output logic [7:0] move_periods,
  output logic [3:0] move_reads,
  output logic [3:0] move_writes,
  output logic [15:0] last_periods,
  output logic [15:0] last_reads,
  output logic [15:0] last_writes,
  output logic [23:0] program_counter
);

  ////////////////////////////////////////////////////////////////////////
  // state

  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic [2:0] per_cnt_reg;
  logic cyc_fetch_reg;
  logic discard_reg;
  logic discard_next;
  logic started_reg;
  logic started_next;
  logic [15:0] opcode_next;
  logic [15:0] nword_next;
  logic opv_next;
  logic nxv_next;
  logic [23:0] pc_next;
  logic [15:0] periods_reg;
  logic [15:0] reads_reg;
  logic [15:0] writes_reg;

  ////////////////////////////////////////////////////////////////////////
  // decode

  // bus cycle ends on the fourth period or the first ready after it
  wire bus_idle = (bus_state_reg == BUS_IDLE);
  wire bus_run = (bus_state_reg == BUS_RUN);
  wire at_last = (per_cnt_reg == `BUS_LAST_PERIOD);
  wire cyc_end = bus_run && at_last && mem_ready; // RULE_07
  wire stall = bus_run && at_last && !mem_ready;
  // queue control from the decoder side
  wire flush = (branch_take || exc_take) && started_reg;
  wire done_ok = instr_done && started_reg && next_valid && !flush;
  wire ext_ok = ext_take && started_reg && next_valid && !flush && !instr_done;
  wire consume = done_ok || ext_ok;
  // words held or owed by the fetch in flight
  wire fetch_live = bus_run && cyc_fetch_reg && !discard_reg;
  wire [1:0] words_held = {1'b0, opcode_valid} + {1'b0, next_valid} +
                          {1'b0, fetch_live};
  wire [1:0] words_kept = words_held - {1'b0, consume};
  wire fetch_want = (words_kept < 2'h2); // RULE_02 RULE_03
  // operand cycles win; no restart in the cycle of the answer
  wire op_start = bus_idle && op_req && !op_done;
  wire fetch_start = bus_idle && !op_req && fetch_want && !flush;
  wire [23:0] fetch_addr = program_counter + `FETCH_STEP;
  wire fill = cyc_end && cyc_fetch_reg && !discard_reg && !flush;
  wire exec_go = !started_reg && opcode_valid && next_valid && !flush;

  ////////////////////////////////////////////////////////////////////////
  // bus sequencer

  // state choice
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: bus_state_next = (op_start || fetch_start) ? BUS_RUN : BUS_IDLE;
      BUS_RUN: bus_state_next = cyc_end ? BUS_IDLE : BUS_RUN;
      default: bus_state_next = BUS_IDLE;
    endcase
  end

  // period counter saturates on the last period while memory waits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_state_reg <= BUS_IDLE;
      per_cnt_reg <= 3'h0;
    end else begin
      bus_state_reg <= bus_state_next;
      if (bus_idle || at_last) per_cnt_reg <= bus_idle ? 3'h0 : per_cnt_reg; // RULE_08
      else per_cnt_reg <= per_cnt_reg + `BUS_PERIOD_STEP; // RULE_07
    end
  end

  // bus pins and operand answer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `ADDR_RESET;
      mem_wdata <= `WORD_RESET;
      cyc_fetch_reg <= 1'b0;
      op_done <= 1'b0;
      op_rdata <= `WORD_RESET;
    end else begin
      op_done <= cyc_end && !cyc_fetch_reg;
      if (cyc_end && !cyc_fetch_reg) op_rdata <= mem_rdata;
      if (cyc_end) mem_req <= 1'b0;
      else if (op_start || fetch_start) mem_req <= 1'b1;
      if (op_start || fetch_start) begin
        mem_we <= op_start && op_we;
        mem_addr <= op_start ? op_addr : fetch_addr;
        mem_wdata <= op_start ? op_wdata : `WORD_RESET;
        cyc_fetch_reg <= fetch_start;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prefetch queue

  // queue next state; flush wins over every other change
  always_comb begin
    opcode_next = opcode_word;
    nword_next = next_word;
    opv_next = opcode_valid;
    nxv_next = next_valid;
    started_next = started_reg;
    pc_next = program_counter;
    discard_next = discard_reg;
    if (cyc_end) discard_next = 1'b0;
    if (flush) begin
      opv_next = 1'b0; // RULE_04 RULE_05
      nxv_next = 1'b0; // RULE_04 RULE_05
      started_next = 1'b0;
      pc_next = jump_target - `FETCH_STEP; // RULE_16
      // a fetch already on the bus still runs, its word is dropped
      if (fetch_live && !cyc_end) discard_next = 1'b1; // RULE_04
    end else begin
      if (done_ok) begin
        opcode_next = next_word;
        opv_next = 1'b1;
        nxv_next = 1'b0; // RULE_03
        started_next = 1'b0;
      end else if (ext_ok) begin
        nxv_next = 1'b0; // RULE_02
      end
      if (fill) begin
        pc_next = mem_addr; // RULE_06
        if (!opcode_valid) begin
          opcode_next = mem_rdata;
          opv_next = 1'b1;
        end else begin
          nword_next = mem_rdata;
          nxv_next = 1'b1;
        end
      end
      if (exec_go) started_next = 1'b1; // RULE_01
    end
  end

  // queue registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      opcode_word <= `WORD_RESET;
      next_word <= `WORD_RESET;
      opcode_valid <= 1'b0;
      next_valid <= 1'b0;
      started_reg <= 1'b0;
      exec_start <= 1'b0;
      discard_reg <= 1'b0;
      program_counter <= `PC_RESET_VALUE;
    end else begin
      opcode_word <= opcode_next;
      next_word <= nword_next;
      opcode_valid <= opv_next;
      next_valid <= nxv_next;
      started_reg <= started_next;
      exec_start <= exec_go; // RULE_01 RULE_16
      discard_reg <= discard_next;
      program_counter <= pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction time counter

  // every clock of the instruction counts, wait periods included
  always_ff @(posedge clk) begin
    if (!nrst) begin
      periods_reg <= `COUNT16_RESET;
      reads_reg <= `COUNT16_RESET;
      writes_reg <= `COUNT16_RESET;
      last_periods <= `COUNT16_RESET;
      last_reads <= `COUNT16_RESET;
      last_writes <= `COUNT16_RESET;
    end else begin
      periods_reg <= exec_go ? `COUNT16_RESET : periods_reg + 16'h0001; // RULE_08
      if (exec_go) begin
        reads_reg <= `COUNT16_RESET;
        writes_reg <= `COUNT16_RESET;
      end else if (cyc_end) begin
        reads_reg <= reads_reg + {15'h0000, !mem_we}; // RULE_09
        writes_reg <= writes_reg + {15'h0000, mem_we}; // RULE_09
      end
      if (done_ok) begin
        last_periods <= periods_reg + 16'h0001; // RULE_09
        last_reads <= reads_reg + {15'h0000, cyc_end && !mem_we};
        last_writes <= writes_reg + {15'h0000, cyc_end && mem_we};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cost calculator

  cost_if cif();
  assign cif.src_mode = src_mode;
  assign cif.dst_mode = dst_mode;
  assign cif.op_long = op_long;
  assign cif.index_long = index_long;
  assign ea_periods = cif.ea_periods;
  assign ea_reads = cif.ea_reads;
  assign ea_writes = cif.ea_writes;
  assign move_periods = cif.move_periods;
  assign move_reads = cif.move_reads;
  assign move_writes = cif.move_writes;

  ea_cost_calc u_calc (
    .clk(clk),
    .nrst(nrst),
    .cost(cif.calc)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [7:0] run_len_reg;
  logic [7:0] stall_len_reg;

  // helper counters of the current bus cycle
  always_ff @(posedge clk) begin
    if (!nrst || bus_idle) begin
      run_len_reg <= `COUNT8_RESET;
      stall_len_reg <= `COUNT8_RESET;
    end else begin
      run_len_reg <= run_len_reg + 8'h01;
      stall_len_reg <= stall_len_reg + {7'h00, stall};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_QUEUE_READY: assert property ( // RULE_01
    exec_start |-> (opcode_valid && next_valid && started_reg))
    else $error("instruction started without both words");
  AST_EXT_REFILL: assert property ( // RULE_02
    ext_ok |=> (fetch_live || fetch_want))
    else $error("extension word taken without refill");
  AST_DONE_FETCH: assert property ( // RULE_03
    (done_ok && bus_idle && !op_req) |=> (fetch_live && mem_req))
    else $error("last fetch not issued at instruction end");
  AST_BRANCH_DROP: assert property ( // RULE_04
    (branch_take && started_reg) |=>
      (!opcode_valid && !next_valid && !exec_start))
    else $error("queue kept words after branch");
  AST_EXC_DROP: assert property ( // RULE_05
    (exc_take && started_reg && !branch_take) |=> (!opcode_valid && !next_valid))
    else $error("queue kept words after exception");
  AST_PC_LAST: assert property ( // RULE_06
    fill |=> (program_counter == $past(mem_addr)))
    else $error("program counter not at last fetched word");
  AST_BUS_FOUR: assert property ( // RULE_07
    $rose(mem_req) |-> mem_req [*4])
    else $error("bus cycle shorter than four periods");
  AST_WAIT_STRETCH: assert property ( // RULE_08
    cyc_end |-> (run_len_reg + 8'h01 == `BUS_CYCLE_PERIODS + stall_len_reg))
    else $error("bus cycle length not four plus waits");
  AST_TIME_COUNT: assert property ( // RULE_09
    done_ok |=> (last_periods == $past(periods_reg) + 16'h0001))
    else $error("instruction period count wrong");

  COV_BRANCH: cover property (branch_take && started_reg ##[1:40] exec_start);
  COV_EXC: cover property (exc_take && started_reg && fetch_live);
  COV_WAIT: cover property (stall ##1 cyc_end);
  COV_EXT: cover property (ext_ok ##[1:20] done_ok);

endmodule : two_word_prefetch_timing

`default_nettype wire
